/* File: hdl/irt_core.sv */
// Summary of operation
// - latency is counted from any request above the mask seen while the sequencer is idle until handler fetch starts
// - entry waits until the cpu finishes its current sequence, possibly zero cycles
// - entry saves status word and program counter, reads vector, plus five core cycles
// - peripheral class b requests compare against the mask in one peripheral cycle
// - handler fetch begins right after entry at the address read from the vector
// - requests at or below the mask stay pending; only strictly higher reach the cpu
// - accepting an interrupt loads its level into the interrupt mask level, or level 15 for the nmi
module irt_core (
  input wire logic mclk, // core clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic nmi_pin, // non-maskable request pin, high active
  input wire logic [3:0] external_level_request_pins_n, // encoded level pins, low active
  input wire logic pa_req, // peripheral class a request
  input wire logic [3:0] pa_level, // peripheral class a priority
  input wire logic pb_req, // peripheral class b request
  input wire logic [3:0] pb_level, // peripheral class b priority
  input wire logic cpu_seq_done, // cpu at a sequence boundary
  input wire logic mask_wr, // cpu rewrites the mask level
  input wire logic [3:0] mask_wdata, // new mask level
  input wire logic [31:0] cpu_status_word, // status word to be saved
  input wire logic [31:0] cpu_pc, // program counter to be saved
  input wire logic [31:0] cpu_sp, // stack pointer before entry
  input wire logic [31:0] vector_base, // vector table base
  input wire logic mem_ack, // longword access done
  input wire logic [31:0] mem_rdata, // read data, valid with mem_ack
  output logic cpu_irq, // accepted request forwarded to cpu
  output logic [3:0] interrupt_mask_level, // current mask level
  output logic mem_req, // longword access request
  output logic mem_we, // access is a write
  output logic [31:0] mem_addr, // access address
  output logic [31:0] mem_wdata, // write data
  output logic fetch_start, // one-cycle pulse: handler fetch begins
  output logic [31:0] fetch_addr, // handler address
  output logic [irt_pkg::LAT_W-1:0] latency_cycles, // last measured latency in core cycles
  output logic latency_valid // one-cycle pulse with latency_cycles
);
  // pin synchronisers
  logic [4:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 5'h0f;
      pin_s2_reg <= 5'h0f;
    end else begin
      pin_s1_reg <= {nmi_pin, external_level_request_pins_n};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // bus and peripheral cycle enables
  logic [3:0] ediv_reg, ediv_next, pdiv_reg, pdiv_next;
  logic e_en, p_en;
  always_comb begin
    e_en = (ediv_reg == 4'(irt_pkg::ECYC_DIV - 1));
    p_en = (pdiv_reg == 4'(irt_pkg::PCYC_DIV - 1));
    ediv_next = e_en ? 4'h0 : ediv_reg + 4'h1;
    pdiv_next = p_en ? 4'h0 : pdiv_reg + 4'h1;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ediv_reg <= 4'h0;
      pdiv_reg <= 4'h0;
    end else begin
      ediv_reg <= ediv_next;
      pdiv_reg <= pdiv_next;
    end
  end

  // source levels; level zero on the pins means no request
  logic [4:0] src_level [irt_pkg::NSRC];
  logic [irt_pkg::NSRC-1:0] src_raw, src_above, src_ready;
  logic [3:0] mask_reg, mask_next;
  always_comb begin
    src_level[irt_pkg::SRC_NMI] = irt_pkg::NMI_LEVEL;
    src_level[irt_pkg::SRC_EXT] = {1'b0, ~pin_s2_reg[3:0]};
    src_level[irt_pkg::SRC_PA] = {1'b0, pa_level};
    src_level[irt_pkg::SRC_PB] = {1'b0, pb_level};
    src_raw[irt_pkg::SRC_NMI] = pin_s2_reg[4];
    src_raw[irt_pkg::SRC_EXT] = (pin_s2_reg[3:0] != 4'hf);
    src_raw[irt_pkg::SRC_PA] = pa_req;
    src_raw[irt_pkg::SRC_PB] = pb_req;
  end

  // one compare delay per source
  genvar g;
  generate
    for (g = 0; g < irt_pkg::NSRC; g++) begin : g_cmp
      assign src_above[g] = src_raw[g] && (src_level[g] > {1'b0, mask_reg});
      irt_cmp_stage #(
        .CORE_N(irt_pkg::CMP_CORE[g]),
        .ECYC_N(irt_pkg::CMP_ECYC[g]),
        .PCYC_N(irt_pkg::CMP_PCYC[g])
      ) u_cmp (
        .mclk(mclk),
        .rst_n(rst_n),
        .req(src_above[g]),
        .e_en(e_en),
        .p_en(p_en),
        .ready(src_ready[g])
      );
    end
  endgenerate

  // highest ready level wins, lower slot on a tie
  logic [1:0] win_src;
  logic [4:0] win_level;
  logic win_any;
  always_comb begin
    win_src = 2'h0;
    win_level = 5'h00;
    win_any = 1'b0;
    for (int i = 0; i < irt_pkg::NSRC; i++) begin
      if (src_ready[i] && (!win_any || src_level[i] > win_level)) begin
        win_src = 2'(i);
        win_level = src_level[i];
        win_any = 1'b1;
      end
    end
  end

  // acceptance and exception entry sequencer
  irt_pkg::irt_state_e st_reg, st_next;
  logic [1:0] acc_src_reg, acc_src_next;
  logic [3:0] acc_lvl_reg, acc_lvl_next;
  logic [3:0] cnt_reg, cnt_next;
  logic irq_reg, irq_next, req_reg, req_next, we_reg, we_next, fs_reg, fs_next, lv_reg, lv_next;
  logic lrun_reg, lrun_next;
  logic [31:0] addr_reg, addr_next, wdata_reg, wdata_next, faddr_reg, faddr_next;
  logic [irt_pkg::LAT_W-1:0] lcnt_reg, lcnt_next, lat_reg, lat_next;

  always_comb begin
    st_next = st_reg;
    acc_src_next = acc_src_reg;
    acc_lvl_next = acc_lvl_reg;
    cnt_next = cnt_reg;
    mask_next = mask_wr ? mask_wdata : mask_reg;
    irq_next = irq_reg;
    req_next = req_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    faddr_next = faddr_reg;
    fs_next = 1'b0;
    lv_next = 1'b0;
    lat_next = lat_reg;
    // latency runs while a request stands or entry is under way
    lrun_next = lrun_reg;
    lcnt_next = lcnt_reg;
    if (lrun_reg) begin
      lcnt_next = lcnt_reg + 1'b1;
    end
    if (st_reg == irt_pkg::IRT_IDLE && !lrun_reg && |src_above) begin
      lrun_next = 1'b1;
      lcnt_next = '0;
    end else if (st_reg == irt_pkg::IRT_IDLE && lrun_reg && ~|src_above) begin
      lrun_next = 1'b0; // withdrawn before acceptance: no sample
    end
    unique case (st_reg)
      irt_pkg::IRT_IDLE: begin
        if (win_any) begin
          acc_src_next = win_src;
          acc_lvl_next = win_level[4] ? irt_pkg::MASK_RST : win_level[3:0];
          irq_next = 1'b1;
          st_next = irt_pkg::IRT_WAIT_SEQ;
        end
      end
      irt_pkg::IRT_WAIT_SEQ: begin
        if (cpu_seq_done) begin
          irq_next = 1'b0;
          mask_next = acc_lvl_reg;
          cnt_next = 4'h0;
          st_next = irt_pkg::IRT_ENTRY;
        end
      end
      irt_pkg::IRT_ENTRY: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == 4'(irt_pkg::ENTRY_CORE - 1)) begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = cpu_sp - irt_pkg::STACK_STEP;
          wdata_next = cpu_status_word;
          st_next = irt_pkg::IRT_SAVE_SR;
        end
      end
      irt_pkg::IRT_SAVE_SR: begin
        if (mem_ack) begin
          addr_next = cpu_sp - (irt_pkg::STACK_STEP << 1);
          wdata_next = cpu_pc;
          st_next = irt_pkg::IRT_SAVE_PC;
        end
      end
      irt_pkg::IRT_SAVE_PC: begin
        if (mem_ack) begin
          we_next = 1'b0;
          wdata_next = 32'h0000_0000;
          addr_next = vector_base + {22'h0, irt_pkg::VEC_NUM[acc_src_reg], 2'b00};
          st_next = irt_pkg::IRT_READ_VEC;
        end
      end
      irt_pkg::IRT_READ_VEC: begin
        if (mem_ack) begin
          req_next = 1'b0;
          faddr_next = mem_rdata;
          st_next = irt_pkg::IRT_FETCH;
        end
      end
      irt_pkg::IRT_FETCH: begin
        fs_next = 1'b1;
        lv_next = lrun_reg;
        lat_next = lcnt_reg + 1'b1;
        lrun_next = 1'b0;
        st_next = irt_pkg::IRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= irt_pkg::IRT_IDLE;
      acc_src_reg <= 2'h0;
      acc_lvl_reg <= 4'h0;
      cnt_reg <= 4'h0;
      mask_reg <= irt_pkg::MASK_RST;
      irq_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      faddr_reg <= 32'h0000_0000;
      fs_reg <= 1'b0;
      lv_reg <= 1'b0;
      lrun_reg <= 1'b0;
      lcnt_reg <= '0;
      lat_reg <= '0;
    end else begin
      st_reg <= st_next;
      acc_src_reg <= acc_src_next;
      acc_lvl_reg <= acc_lvl_next;
      cnt_reg <= cnt_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      req_reg <= req_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      faddr_reg <= faddr_next;
      fs_reg <= fs_next;
      lv_reg <= lv_next;
      lrun_reg <= lrun_next;
      lcnt_reg <= lcnt_next;
      lat_reg <= lat_next;
    end
  end

  assign cpu_irq = irq_reg;
  assign interrupt_mask_level = mask_reg;
  assign mem_req = req_reg;
  assign mem_we = we_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign fetch_start = fs_reg;
  assign fetch_addr = faddr_reg;
  assign latency_cycles = lat_reg;
  assign latency_valid = lv_reg;
endmodule

/* File: hdl/irt_pkg.sv */
package irt_pkg;
  // source slots, lowest index wins a tie in level
  localparam int NSRC = 4;
  localparam int SRC_NMI = 0;
  localparam int SRC_EXT = 1;
  localparam int SRC_PA = 2;
  localparam int SRC_PB = 3;

  // clock ratios: external-bus and peripheral cycles as core-cycle multiples
  localparam int ECYC_DIV = 2;
  localparam int PCYC_DIV = 2;

  // compare phase per source: core cycles, bus cycles, peripheral cycles
  // half cycles round up to whole ones
  localparam int CMP_CORE [NSRC] = '{2, 1, 1, 0};
  localparam int CMP_ECYC [NSRC] = '{0, 1, 0, 0};
  localparam int CMP_PCYC [NSRC] = '{0, 2, 1, 1};

  // exception entry core cycles besides the three memory accesses
  localparam int ENTRY_CORE = 5;

  // vector numbers per source slot
  localparam logic [7:0] VEC_NUM [NSRC] = '{8'h0b, 8'h40, 8'h48, 8'h50};

  localparam logic [3:0] MASK_RST = 4'hf;
  localparam logic [4:0] NMI_LEVEL = 5'h10;
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam int LAT_W = 16;

  typedef enum logic [2:0] {
    IRT_IDLE, IRT_WAIT_SEQ, IRT_ENTRY, IRT_SAVE_SR, IRT_SAVE_PC, IRT_READ_VEC, IRT_FETCH
  } irt_state_e;

  typedef enum logic [1:0] {IRT_PH_CORE, IRT_PH_ECYC, IRT_PH_PCYC, IRT_PH_DONE} irt_phase_e;
endpackage

/* File: hdl/irt_cmp_stage.sv */
// priority compare delay for one source: core, then bus, then peripheral cycles
module irt_cmp_stage #(
  parameter int CORE_N = 0,
  parameter int ECYC_N = 0,
  parameter int PCYC_N = 0
) (
  input wire logic mclk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic req, // request qualified above the mask
  input wire logic e_en, // bus cycle enable
  input wire logic p_en, // peripheral cycle enable
  output logic ready // compare finished, request still standing
);
  irt_pkg::irt_phase_e ph_reg, ph_next;
  logic [3:0] cnt_reg, cnt_next;

  // phases with a zero count are skipped outright, so they add no core cycle to the compare
  localparam irt_pkg::irt_phase_e AFTER_ECYC =
    irt_pkg::irt_phase_e'((PCYC_N != 0) ? irt_pkg::IRT_PH_PCYC : irt_pkg::IRT_PH_DONE);
  localparam irt_pkg::irt_phase_e AFTER_CORE =
    irt_pkg::irt_phase_e'((ECYC_N != 0) ? irt_pkg::IRT_PH_ECYC : AFTER_ECYC);
  localparam irt_pkg::irt_phase_e FIRST_PH =
    irt_pkg::irt_phase_e'((CORE_N != 0) ? irt_pkg::IRT_PH_CORE : AFTER_CORE);

  // a dropped request restarts the whole compare, no partial credit kept
  always_comb begin
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    if (!req) begin
      ph_next = FIRST_PH;
      cnt_next = 4'h0;
    end else begin
      unique case (ph_reg)
        irt_pkg::IRT_PH_CORE: begin
          if (cnt_reg == 4'(CORE_N - 1)) begin
            ph_next = AFTER_CORE;
            cnt_next = 4'h0;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        irt_pkg::IRT_PH_ECYC: begin
          if (e_en) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'(ECYC_N - 1)) begin
              ph_next = AFTER_ECYC;
              cnt_next = 4'h0;
            end
          end
        end
        irt_pkg::IRT_PH_PCYC: begin
          if (p_en) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'(PCYC_N - 1)) begin
              ph_next = irt_pkg::IRT_PH_DONE;
            end
          end
        end
        irt_pkg::IRT_PH_DONE: begin
          ph_next = irt_pkg::IRT_PH_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= FIRST_PH;
      cnt_reg <= 4'h0;
    end else begin
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
    end
  end

  assign ready = req && (ph_reg == irt_pkg::IRT_PH_DONE);
endmodule

/* File: verif/irt_core_props.sv */
module irt_core_props (
  input wire logic mclk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic nmi_pin, // nmi request
  input wire logic cpu_seq_done, // sequence boundary
  input wire logic [31:0] cpu_status_word, // status to save
  input wire logic [31:0] cpu_pc, // pc to save
  input wire logic [31:0] cpu_sp, // stack pointer
  input wire logic mem_ack, // access done
  input wire logic [31:0] mem_rdata, // read data
  input wire logic cpu_irq, // forwarded request
  input wire logic [3:0] interrupt_mask_level, // mask
  input wire logic mem_req, // access request
  input wire logic mem_we, // write access
  input wire logic [31:0] mem_addr, // access address
  input wire logic [31:0] mem_wdata, // write data
  input wire logic fetch_start, // fetch pulse
  input wire logic [31:0] fetch_addr, // handler address
  input wire logic latency_valid // latency pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [3:0] nmi_age_reg;
  logic [3:0] nmi_age_next;
  // saturating age of the nmi level, so an old pulse never looks recent
  always_comb begin
    nmi_age_next = nmi_age_reg;
    if (nmi_pin) begin
      nmi_age_next = 4'h0;
    end else if (nmi_age_reg != 4'hf) begin
      nmi_age_next = nmi_age_reg + 4'h1;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_age_reg <= 4'hf;
    end else begin
      nmi_age_reg <= nmi_age_next;
    end
  end
  chk_irq_hold: assert property (cpu_irq && !cpu_seq_done |=> cpu_irq)
    else $error("irq dropped before sequence end");
  chk_entry_gap: assert property ($fell(cpu_irq) |-> !mem_req [*4] ##[1:3]
    (mem_req && mem_we && mem_addr == cpu_sp - 32'h4 && mem_wdata == cpu_status_word))
    else $error("status save wrong");
  chk_pc_save: assert property (mem_req && mem_ack && mem_we && mem_addr == cpu_sp - 32'h4 |=>
    mem_req && mem_we && mem_addr == cpu_sp - 32'h8 && mem_wdata == cpu_pc)
    else $error("pc save wrong");
  chk_vec_read: assert property (mem_req && mem_ack && mem_we && mem_addr == cpu_sp - 32'h8 |=>
    mem_req && !mem_we)
    else $error("vector read missing");
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("access changed before ack");
  chk_fetch_go: assert property (mem_req && !mem_we && mem_ack |=>
    !mem_req && fetch_addr == $past(mem_rdata) ##1 fetch_start)
    else $error("fetch not started from vector");
  chk_lat_pulse: assert property (fetch_start |-> latency_valid ##1 !fetch_start)
    else $error("latency pulse wrong");
  chk_nmi_only: assert property ($rose(cpu_irq) && interrupt_mask_level == 4'hf |-> nmi_age_reg < 4'hc)
    else $error("masked request forwarded");
  chk_mask_load: assert property ($fell(cpu_irq) |->
    interrupt_mask_level != $past(interrupt_mask_level) || interrupt_mask_level == 4'hf)
    else $error("mask not loaded");
endmodule

bind irt_core irt_core_props i_props (.mclk, .rst_n, .nmi_pin, .cpu_seq_done, .cpu_status_word, .cpu_pc,
  .cpu_sp, .mem_ack, .mem_rdata, .cpu_irq, .interrupt_mask_level, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .fetch_start, .fetch_addr, .latency_valid);

/* File: verif/irt_mem_model.sv */
module irt_mem_model (
  input wire logic mclk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic mem_req, // access request
  input wire logic [31:0] mem_addr, // access address
  input wire logic [3:0] delay, // ack comes this many cycles plus one after the request
  output logic mem_ack, // access done
  output logic [31:0] mem_rdata // read data, valid with ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // registered ack: at least one wait state; data toggles when not acked
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt == delay) begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      mem_rdata <= mem_addr ^ 32'h8000_0000;
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* File: verif/irt_core_tb.sv */
module irt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SR_VAL = 32'h0000_00f0;
  localparam logic [31:0] PC_VAL = 32'h0000_1234;
  localparam logic [31:0] SP_VAL = 32'h0000_8000;
  localparam logic [31:0] VB_VAL = 32'h0001_0000;
  logic mclk, rst_n, nmi_pin, pa_req, pb_req, cpu_seq_done, mask_wr, mem_ack, seen_irq;
  logic [3:0] ext_n, pa_level, pb_level, mask_wdata, mem_delay, mask_lvl;
  logic [31:0] mem_rdata, mem_addr, mem_wdata, fetch_addr;
  logic cpu_irq, mem_req, mem_we, fetch_start, latency_valid;
  logic [15:0] lat;
  int bad_count, num_checks;

  irt_core i_dut (.mclk, .rst_n, .nmi_pin, .external_level_request_pins_n(ext_n), .pa_req, .pa_level,
    .pb_req, .pb_level, .cpu_seq_done, .mask_wr, .mask_wdata, .cpu_status_word(SR_VAL), .cpu_pc(PC_VAL),
    .cpu_sp(SP_VAL), .vector_base(VB_VAL), .mem_ack, .mem_rdata, .cpu_irq, .interrupt_mask_level(mask_lvl),
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .fetch_start, .fetch_addr, .latency_cycles(lat), .latency_valid);
  irt_mem_model i_mem (.mclk, .rst_n, .mem_req, .mem_addr, .delay(mem_delay), .mem_ack, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // sticky flag: did the block forward anything since the test cleared it
  always @(posedge mclk) begin
    if (cpu_irq === 1'b1) seen_irq <= 1'b1;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // latency shifts with divider phase, so it is judged against a window
  task chk_win(input logic [15:0] got, input int lo, input int hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task drive(input int src, input logic on, input logic [3:0] lv);
    case (src)
      irt_pkg::SRC_NMI: nmi_pin = on;
      irt_pkg::SRC_EXT: ext_n = on ? ~lv : 4'hf;
      irt_pkg::SRC_PA: begin
        pa_req = on;
        pa_level = lv;
      end
      default: begin
        pb_req = on;
        pb_level = lv;
      end
    endcase
  endtask
  task set_mask(input logic [3:0] m);
    @(negedge mclk);
    mask_wr = 1'b1;
    mask_wdata = m;
    @(negedge mclk);
    mask_wr = 1'b0;
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    if (n == 300) chk(s, 1'b1);
  endtask
  // drop the source once entry runs, so a held level is not taken twice
  task run_one(input int src, input logic [3:0] lv);
    drive(src, 1'b1, lv);
    wait_hi(mem_req);
    drive(src, 1'b0, lv);
    wait_hi(fetch_start);
  endtask
  function automatic logic [31:0] exp_fetch(input int src);
    return (VB_VAL + {22'h0, irt_pkg::VEC_NUM[src], 2'b00}) ^ 32'h8000_0000;
  endfunction

  task t_reset;
    chk(mask_lvl, irt_pkg::MASK_RST);
    chk(mem_req, 1'b0);
    seen_irq = 1'b0;
    drive(irt_pkg::SRC_PB, 1'b1, 4'he);
    repeat (30) @(negedge mclk);
    chk(seen_irq, 1'b0);
    drive(irt_pkg::SRC_PB, 1'b0, 4'h0);
    $display("t_reset done");
  endtask
  task t_sources;
    for (int i = 0; i < irt_pkg::NSRC; i++) begin
      mem_delay = 4'(i);
      set_mask(i == irt_pkg::SRC_NMI ? 4'hf : 4'h3);
      run_one(i, 4'h6);
      chk(fetch_addr, exp_fetch(i));
      chk(mask_lvl, i == irt_pkg::SRC_NMI ? 4'hf : 4'h6);
      chk_win(lat, 5 + 3 * (i + 1), 25 + 3 * (i + 1));
      repeat (6) @(negedge mclk);
    end
    $display("t_sources done");
  endtask
  task t_seq_wait;
    mem_delay = 4'h0;
    cpu_seq_done = 1'b0;
    set_mask(4'h0);
    drive(irt_pkg::SRC_PB, 1'b1, 4'h4);
    wait_hi(cpu_irq);
    repeat (20) @(negedge mclk);
    chk(cpu_irq, 1'b1);
    chk(mem_req, 1'b0);
    cpu_seq_done = 1'b1;
    wait_hi(mem_req);
    drive(irt_pkg::SRC_PB, 1'b0, 4'h4);
    wait_hi(fetch_start);
    chk_win(lat, 28, 50);
    chk(mask_lvl, 4'h4);
    $display("t_seq_wait done");
  endtask
  task t_order;
    set_mask(4'h2);
    drive(irt_pkg::SRC_PA, 1'b1, 4'h7);
    run_one(irt_pkg::SRC_PB, 4'h9);
    drive(irt_pkg::SRC_PA, 1'b0, 4'h7);
    chk(fetch_addr, exp_fetch(irt_pkg::SRC_PB));
    chk(mask_lvl, 4'h9);
    repeat (6) @(negedge mclk);
    seen_irq = 1'b0;
    drive(irt_pkg::SRC_PA, 1'b1, 4'h9);
    repeat (30) @(negedge mclk);
    chk(seen_irq, 1'b0);
    run_one(irt_pkg::SRC_PA, 4'ha);
    chk(mask_lvl, 4'ha);
    $display("t_order done");
  endtask

  initial begin
    rst_n = 1'b0;
    nmi_pin = 1'b0;
    ext_n = 4'hf;
    drive(irt_pkg::SRC_PA, 1'b0, 4'h0);
    drive(irt_pkg::SRC_PB, 1'b0, 4'h0);
    cpu_seq_done = 1'b1;
    mask_wr = 1'b0;
    mask_wdata = 4'h0;
    mem_delay = 4'h0;
    seen_irq = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    t_reset;
    t_sources;
    t_seq_wait;
    t_order;
    end_of_test;
  end
  // the tests need well under a thousand cycles; this leaves wide margin
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    end_of_test;
  end
endmodule
